/* verilog/flc_consts.vh */
// register offsets, field positions, reset values and timing counts for the loop control block
`ifndef FLC_CONSTS_VH
`define FLC_CONSTS_VH

// register offsets
`define FLC_ADDR_L1_CTRL      12'h171
`define FLC_ADDR_L1_SPREAD    12'h189
`define FLC_ADDR_L2_CTRL      12'h191
`define FLC_ADDR_L2_UPD_INT   12'h192
`define FLC_ADDR_L2_NUM       12'h193
`define FLC_ADDR_L2_DEN       12'h194
`define FLC_ADDR_L2_RATIO     12'h195
`define FLC_ADDR_L2_REFSRC    12'h196
`define FLC_ADDR_L2_GAIN      12'h199
`define FLC_ADDR_L2_SYNC_EN   12'h1a1
`define FLC_ADDR_L2_SYNC_INT  12'h1a2
`define FLC_ADDR_L2_SYNC_NUM  12'h1a3
`define FLC_ADDR_L2_SYNC_DEN  12'h1a4
`define FLC_ADDR_L2_SYNC_RAT  12'h1a5
`define FLC_ADDR_L2_SYNC_SRC  12'h1a6
`define FLC_ADDR_L2_SYNC_GBW  12'h1a7
`define FLC_ADDR_L2_SPREAD    12'h1a9
`define FLC_ADDR_STATUS       12'h1af

// field positions
`define FLC_BIT_ENABLE        0
`define FLC_BIT_FREERUN       1
`define FLC_BIT_APPLY         15
`define FLC_BIT_BANDWIDTH     0

// reset values
`define FLC_RST_INT_MULT      10'h008
`define FLC_RST_FRAC_NUM      16'h0018
`define FLC_RST_FRAC_DEN      16'h007d
`define FLC_RST_OUT_DIV       3'h2
`define FLC_RST_L1_FREERUN    1'b1
`define FLC_RST_L2_FREERUN    1'b0
`define FLC_RST_SYNC_BW       1'b1

// timing counts
`define FLC_START_CYCLES      16'h0100
`define FLC_LOCK_CYCLES       16'h0400
`define FLC_REF_LOSS_CYCLES   16'h0800

`endif

/* verilog/flc_ref_monitor.v */
// pin synchronisers, reference source select and edge watcher for the loop reference
`timescale 1ns/100ps
`include "flc_consts.vh"

module flc_ref_monitor
#(
  parameter LOSS_CYCLES = `FLC_REF_LOSS_CYCLES,
  parameter PIN_COUNT   = 11
)
(
  // clock and reset
  input  wire                 sys_clk,
  input  wire                 reset_n,
  // reference pins, loop clock-good levels and the code that picks a source
  input  wire [PIN_COUNT-1:0] refPins,
  input  wire [3:0]           refSource,
  input  wire [1:0]           loopClockGood,
  // reference seen recently
  output reg                  refPresent_r,
  // one pulse per rising reference edge
  output reg                  refEdge_r
);

  wire [PIN_COUNT-1:0] pinSync;
  reg                  refMux;
  reg                  refLast_r;
  reg  [15:0]          idle_r;

  // two flip-flops per pin ahead of the source mux, so no logic ever reads a raw pin
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1)
    begin : gen_pin_sync
      reg meta_r;
      reg sync_r;
      always @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end
        else
        begin
          meta_r <= refPins[g];
          sync_r <= meta_r;
        end
      end
      assign pinSync[g] = sync_r;
    end
  endgenerate

  // source decode; reserved codes give no reference, so the loop drops to free-run
  always @*
  begin
    refMux = 1'b0;
    case (refSource)
      4'h0: refMux = pinSync[0];
      4'h1: refMux = pinSync[1];
      4'h3: refMux = pinSync[2];
      4'h4: refMux = loopClockGood[0];
      4'h5: refMux = loopClockGood[1];
      4'h8: refMux = pinSync[3];
      4'h9: refMux = pinSync[4];
      4'ha: refMux = pinSync[5];
      4'hc: refMux = pinSync[6];
      4'hd: refMux = pinSync[7];
      4'he: refMux = pinSync[8];
      default: refMux = 1'b0;
    endcase
  end

  // edge watcher and loss timer; a source switch may show one spurious edge
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      refLast_r    <= 1'b0;
      idle_r       <= 16'h0000;
      refPresent_r <= 1'b0;
      refEdge_r    <= 1'b0;
    end
    else
    begin
      refLast_r <= refMux;
      refEdge_r <= refMux & ~refLast_r;
      // a stalled reference is declared lost after the idle count runs out
      if (refMux & ~refLast_r)
      begin
        idle_r       <= 16'h0000;
        refPresent_r <= 1'b1;
      end
      else if (idle_r == LOSS_CYCLES[15:0])
        refPresent_r <= 1'b0;
      else
        idle_r <= idle_r + 16'h0001;
    end
  end

endmodule

/* verilog/flc_loop_ctrl.v */
// register file and sequencing for two frequency-locked loops
//
// Overview of operation
// - while enabled, new multiplier and numerator wait for the apply strobe bit 15
// - integer multiplier 10 bits reset 008h, numerator 16 bits reset 0018h
// - denominator 16 bits reset 007Dh, never gated by the apply strobe
// - ratio codes 000..011 give 1,2,4,8; top bit set gives 16
// - output divider code 2..7 divides; codes 0 and 1 reserved; reset 010
// - reference divider codes 00..11 give 1,2,4,8; software keeps reference low
// - source select picks master, bus, loop, bit or frame clocks; rest reserved
// - gain codes 0..7 double from 1 to 128; codes 8..15 give 256
// - synchroniser has own multiplier, numerator, denominator, all reset zero
// - synchroniser reference divider gives 1,2,4,8, reset code 00; here only stored and read back
// - synchroniser bandwidth bit: 0 wide, 1 narrow, reset 1
// - free-run halts feedback and holds integrator; resets 1 for loop1, 0 loop2
// - entering free-run from lock keeps output frequency unchanged
// - lost reference forces free-run; with free-run clear, relock when it returns; here only loop 2 has its reference watched
// - spread type: off, triangle, zero-mean modulation or dither per loop
// - spread depth field sets modulation depth code per loop
// - spread rate field sets triangle modulation rate code
// - each loop reports clock-good and lock status
// - status signals drive event and general-purpose output ports
`timescale 1ns/100ps
`include "flc_consts.vh"

module flc_loop_ctrl
#(
  parameter START_CYCLES = `FLC_START_CYCLES,
  parameter LOCK_CYCLES  = `FLC_LOCK_CYCLES
)
(
  // clock and reset
  input  wire        sys_clk,
  input  wire        reset_n,
  // register port
  input  wire [11:0] regAddr,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata_r,
  // reference pins: master a, master b, serial bus, port bit and frame clocks
  input  wire [10:0] refPins,
  // loop 2 and loop 1 active settings to the analogue loops
  output reg         loop2Run_r,
  output reg  [9:0]  loop2IntMult_r,
  output reg  [15:0] loop2FracNum_r,
  output reg  [15:0] loop2FracDen_r,
  output reg  [4:0]  loop2OscRatio_r,
  output reg  [2:0]  loop2OutDivider_r,
  output reg  [3:0]  loop2RefDivider_r,
  output reg  [8:0]  loop2LoopGain_r,
  output reg         loop2Hold_r,
  output reg  [1:0]  loop2SpreadType_r,
  output reg  [1:0]  loop2SpreadDepth_r,
  output reg  [1:0]  loop2SpreadRate_r,
  output reg  [1:0]  loop1SpreadType_r,
  output reg  [1:0]  loop1SpreadDepth_r,
  output reg  [1:0]  loop1SpreadRate_r,
  output reg         loop1Run_r,
  output reg         loop1Hold_r,
  output reg         loop2SyncRun_r,
  output reg         loop2SyncBandwidth_r,
  // status to interrupt and general-purpose output logic
  output reg  [1:0]  clockGood_r,
  output reg  [1:0]  lockStat_r,
  output reg  [3:0]  statusEvent_r
);

  // programmed fields
  reg        l1Enable_r;
  reg        l1FreeRun_r;
  reg [5:0]  l1Spread_r;
  reg        l2Enable_r;
  reg        l2FreeRun_r;
  reg [9:0]  l2IntStage_r;
  reg [15:0] l2NumStage_r;
  reg [15:0] l2Den_r;
  reg [2:0]  l2Ratio_r;
  reg [2:0]  l2OutDiv_r;
  reg [1:0]  l2RefDiv_r;
  reg [3:0]  l2RefSrc_r;
  reg [3:0]  l2Gain_r;
  reg        l2SyncEn_r;
  reg [9:0]  l2SyncInt_r;
  reg [15:0] l2SyncNum_r;
  reg [15:0] l2SyncDen_r;
  reg [2:0]  l2SyncRatio_r;
  reg [1:0]  l2SyncDiv_r;
  reg [3:0]  l2SyncSrc_r;
  reg [3:0]  l2SyncGain_r;
  reg        l2SyncBw_r;
  reg [5:0]  l2Spread_r;
  reg        applyPulse_r;
  reg [15:0] cnt1_r;
  reg [15:0] cnt2_r;
  reg [1:0]  clockGoodPrev_r;
  reg [1:0]  lockPrev_r;

  wire       refPresent;
  wire       refEdge;

  // pins are synchronised inside the monitor before the source select looks at them
  flc_ref_monitor u_refmon
  (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .refPins       (refPins),
    .refSource     (l2RefSrc_r),
    .loopClockGood (clockGood_r),
    .refPresent_r  (refPresent),
    .refEdge_r     (refEdge)
  );

  // register writes; apply strobe never stored, it only fires a pulse
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      l1Enable_r    <= 1'b0;
      l1FreeRun_r   <= `FLC_RST_L1_FREERUN;
      l1Spread_r    <= 6'h00;
      l2Enable_r    <= 1'b0;
      l2FreeRun_r   <= `FLC_RST_L2_FREERUN;
      l2IntStage_r  <= `FLC_RST_INT_MULT;
      l2NumStage_r  <= `FLC_RST_FRAC_NUM;
      l2Den_r       <= `FLC_RST_FRAC_DEN;
      l2Ratio_r     <= 3'h0;
      l2OutDiv_r    <= `FLC_RST_OUT_DIV;
      l2RefDiv_r    <= 2'h0;
      l2RefSrc_r    <= 4'h0;
      l2Gain_r      <= 4'h0;
      l2SyncEn_r    <= 1'b0;
      l2SyncInt_r   <= 10'h000;
      l2SyncNum_r   <= 16'h0000;
      l2SyncDen_r   <= 16'h0000;
      l2SyncRatio_r <= 3'h0;
      l2SyncDiv_r   <= 2'h0;
      l2SyncSrc_r   <= 4'h0;
      l2SyncGain_r  <= 4'h0;
      l2SyncBw_r    <= `FLC_RST_SYNC_BW;
      l2Spread_r    <= 6'h00;
      applyPulse_r  <= 1'b0;
    end
    else
    begin
      applyPulse_r <= 1'b0;
      if (regWrite)
      begin
        case (regAddr)
          `FLC_ADDR_L1_CTRL:
          begin
            l1Enable_r  <= regWdata[`FLC_BIT_ENABLE];
            l1FreeRun_r <= regWdata[`FLC_BIT_FREERUN];
          end
          `FLC_ADDR_L1_SPREAD: l1Spread_r <= regWdata[5:0];
          `FLC_ADDR_L2_CTRL:
          begin
            l2Enable_r  <= regWdata[`FLC_BIT_ENABLE];
            l2FreeRun_r <= regWdata[`FLC_BIT_FREERUN];
          end
          `FLC_ADDR_L2_UPD_INT:
          begin
            l2IntStage_r <= regWdata[9:0];
            applyPulse_r <= regWdata[`FLC_BIT_APPLY] & l2Enable_r;
          end
          `FLC_ADDR_L2_NUM:      l2NumStage_r  <= regWdata;
          `FLC_ADDR_L2_DEN:      l2Den_r       <= regWdata;
          `FLC_ADDR_L2_RATIO:
          begin
            l2Ratio_r  <= regWdata[10:8];
            l2OutDiv_r <= regWdata[3:1];
          end
          `FLC_ADDR_L2_REFSRC:
          begin
            l2RefDiv_r <= regWdata[7:6];
            l2RefSrc_r <= regWdata[3:0];
          end
          `FLC_ADDR_L2_GAIN:     l2Gain_r      <= regWdata[5:2];
          `FLC_ADDR_L2_SYNC_EN:  l2SyncEn_r    <= regWdata[`FLC_BIT_ENABLE];
          `FLC_ADDR_L2_SYNC_INT: l2SyncInt_r   <= regWdata[9:0];
          `FLC_ADDR_L2_SYNC_NUM: l2SyncNum_r   <= regWdata;
          `FLC_ADDR_L2_SYNC_DEN: l2SyncDen_r   <= regWdata;
          `FLC_ADDR_L2_SYNC_RAT: l2SyncRatio_r <= regWdata[10:8];
          `FLC_ADDR_L2_SYNC_SRC:
          begin
            l2SyncDiv_r <= regWdata[7:6];
            l2SyncSrc_r <= regWdata[3:0];
          end
          `FLC_ADDR_L2_SYNC_GBW:
          begin
            l2SyncGain_r <= regWdata[5:2];
            l2SyncBw_r   <= regWdata[`FLC_BIT_BANDWIDTH];
          end
          `FLC_ADDR_L2_SPREAD:   l2Spread_r    <= regWdata[5:0];
          default: ;
        endcase
      end
    end
  end

  // active multiplier and numerator: follow staging while off, load on strobe while on
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loop2IntMult_r <= `FLC_RST_INT_MULT;
      loop2FracNum_r <= `FLC_RST_FRAC_NUM;
    end
    else if (!l2Enable_r || applyPulse_r)
    begin
      loop2IntMult_r <= l2IntStage_r;
      loop2FracNum_r <= l2NumStage_r;
    end
  end

  // decoded settings and spread controls to the analogue side
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loop2FracDen_r       <= `FLC_RST_FRAC_DEN;
      loop2OscRatio_r      <= 5'h01;
      loop2OutDivider_r    <= `FLC_RST_OUT_DIV;
      loop2RefDivider_r    <= 4'h1;
      loop2LoopGain_r      <= 9'h001;
      loop2SpreadType_r    <= 2'h0;
      loop2SpreadDepth_r   <= 2'h0;
      loop2SpreadRate_r    <= 2'h0;
      loop1SpreadType_r    <= 2'h0;
      loop1SpreadDepth_r   <= 2'h0;
      loop1SpreadRate_r    <= 2'h0;
      loop1Run_r           <= 1'b0;
      loop2Run_r           <= 1'b0;
      loop2SyncRun_r       <= 1'b0;
      loop2SyncBandwidth_r <= `FLC_RST_SYNC_BW;
      loop1Hold_r          <= 1'b0;
      loop2Hold_r          <= 1'b0;
      clockGoodPrev_r      <= 2'b00;
      lockPrev_r           <= 2'b00;
      statusEvent_r        <= 4'h0;
    end
    else
    begin
      loop2FracDen_r       <= l2Den_r;
      loop2OscRatio_r      <= l2Ratio_r[2] ? 5'h10 : 5'h01 << l2Ratio_r[1:0];
      // reserved divider codes fall back to divide by 2
      loop2OutDivider_r    <= (l2OutDiv_r[2:1] == 2'b00) ? `FLC_RST_OUT_DIV : l2OutDiv_r;
      loop2RefDivider_r    <= 4'h1 << l2RefDiv_r;
      loop2LoopGain_r      <= l2Gain_r[3] ? 9'h100 : 9'h001 << l2Gain_r[2:0];
      loop2SpreadType_r    <= l2Spread_r[1:0];
      loop2SpreadDepth_r   <= l2Spread_r[5:4];
      loop2SpreadRate_r    <= l2Spread_r[3:2];
      loop1SpreadType_r    <= l1Spread_r[1:0];
      loop1SpreadDepth_r   <= l1Spread_r[5:4];
      loop1SpreadRate_r    <= l1Spread_r[3:2];
      loop1Run_r           <= l1Enable_r;
      loop2Run_r           <= l2Enable_r;
      loop2SyncRun_r       <= l2SyncEn_r & l2Enable_r;
      loop2SyncBandwidth_r <= l2SyncBw_r;
      // hold integrator in free-run, loop 2 also when its reference is gone; lock resumes on return
      loop1Hold_r          <= l1Enable_r & l1FreeRun_r;
      loop2Hold_r          <= l2Enable_r & (l2FreeRun_r | ~refPresent);
      // one-cycle event on any status change, for the interrupt block
      clockGoodPrev_r      <= clockGood_r;
      lockPrev_r           <= lockStat_r;
      statusEvent_r        <= {lockStat_r ^ lockPrev_r, clockGood_r ^ clockGoodPrev_r};
    end
  end

  // start-up and lock timers; loop1 has no monitored reference here so it locks unless held
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt1_r      <= 16'h0000;
      cnt2_r      <= 16'h0000;
      clockGood_r <= 2'b00;
      lockStat_r  <= 2'b00;
    end
    else
    begin
      if (!l1Enable_r)
      begin
        cnt1_r      <= 16'h0000;
        clockGood_r[0] <= 1'b0;
        lockStat_r[0]  <= 1'b0;
      end
      else
      begin
        if (cnt1_r != LOCK_CYCLES[15:0])
          cnt1_r <= cnt1_r + 16'h0001;
        clockGood_r[0] <= (cnt1_r >= START_CYCLES[15:0]);
        lockStat_r[0]  <= (cnt1_r == LOCK_CYCLES[15:0]) & ~l1FreeRun_r;
      end
      if (!l2Enable_r)
      begin
        cnt2_r      <= 16'h0000;
        clockGood_r[1] <= 1'b0;
        lockStat_r[1]  <= 1'b0;
      end
      else
      begin
        // lock count is pulled back to the start count while held, so lock restarts after the loop leaves hold
        if (loop2Hold_r && cnt2_r > START_CYCLES[15:0])
          cnt2_r <= START_CYCLES[15:0];
        else if (cnt2_r != LOCK_CYCLES[15:0] && (refEdge || cnt2_r < START_CYCLES[15:0]
                 || loop2Hold_r))
          cnt2_r <= cnt2_r + 16'h0001;
        clockGood_r[1] <= (cnt2_r >= START_CYCLES[15:0]);
        lockStat_r[1]  <= (cnt2_r == LOCK_CYCLES[15:0]) & ~loop2Hold_r;
      end
    end
  end

  // read mux; apply bit reads as zero, unmapped reads zero
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata_r <= 16'h0000;
    else if (regRead)
    begin
      case (regAddr)
        `FLC_ADDR_L1_CTRL:     regRdata_r <= {14'h0000, l1FreeRun_r, l1Enable_r};
        `FLC_ADDR_L1_SPREAD:   regRdata_r <= {10'h000, l1Spread_r};
        `FLC_ADDR_L2_CTRL:     regRdata_r <= {14'h0000, l2FreeRun_r, l2Enable_r};
        `FLC_ADDR_L2_UPD_INT:  regRdata_r <= {6'h00, l2IntStage_r};
        `FLC_ADDR_L2_NUM:      regRdata_r <= l2NumStage_r;
        `FLC_ADDR_L2_DEN:      regRdata_r <= l2Den_r;
        `FLC_ADDR_L2_RATIO:    regRdata_r <= {5'h00, l2Ratio_r, 4'h0, l2OutDiv_r, 1'b0};
        `FLC_ADDR_L2_REFSRC:   regRdata_r <= {8'h00, l2RefDiv_r, 2'h0, l2RefSrc_r};
        `FLC_ADDR_L2_GAIN:     regRdata_r <= {10'h000, l2Gain_r, 2'h0};
        `FLC_ADDR_L2_SYNC_EN:  regRdata_r <= {15'h0000, l2SyncEn_r};
        `FLC_ADDR_L2_SYNC_INT: regRdata_r <= {6'h00, l2SyncInt_r};
        `FLC_ADDR_L2_SYNC_NUM: regRdata_r <= l2SyncNum_r;
        `FLC_ADDR_L2_SYNC_DEN: regRdata_r <= l2SyncDen_r;
        `FLC_ADDR_L2_SYNC_RAT: regRdata_r <= {5'h00, l2SyncRatio_r, 8'h00};
        `FLC_ADDR_L2_SYNC_SRC: regRdata_r <= {8'h00, l2SyncDiv_r, 2'h0, l2SyncSrc_r};
        `FLC_ADDR_L2_SYNC_GBW: regRdata_r <= {10'h000, l2SyncGain_r, 1'b0, l2SyncBw_r};
        `FLC_ADDR_L2_SPREAD:   regRdata_r <= {10'h000, l2Spread_r};
        `FLC_ADDR_STATUS:      regRdata_r <= {10'h000, refPresent, loop2Hold_r,
                                              lockStat_r, clockGood_r};
        default:               regRdata_r <= 16'h0000;
      endcase
    end
  end

endmodule

/* test/flc_loop_ctrl_assertions.sv */
// concurrent checks on the loop control register port and decoded loop 2 outputs
`timescale 1ns/100ps
module flc_loop_ctrl_checker
(
  // clock and reset
  input wire        sys_clk,
  input wire        reset_n,
  // register port
  input wire [11:0] regAddr,
  input wire        regWrite,
  input wire        regRead,
  input wire [15:0] regWdata,
  input wire [15:0] regRdata_r,
  // loop 2 active settings and status
  input wire        loop2Run_r,
  input wire [9:0]  loop2IntMult_r,
  input wire [15:0] loop2FracDen_r,
  input wire [4:0]  loop2OscRatio_r,
  input wire [2:0]  loop2OutDivider_r,
  input wire [3:0]  loop2RefDivider_r,
  input wire [8:0]  loop2LoopGain_r,
  input wire [1:0]  clockGood_r,
  input wire [1:0]  lockStat_r
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // an apply write to the update and integer register
  wire applyWrite;
  assign applyWrite = regWrite && regAddr == 12'h192 && regWdata[15];

  // running loop keeps its multiplier unless an apply write came two edges back
  AST_APPLY_GATED: assert property (loop2Run_r && $past(loop2Run_r, 3) &&
    !$past(applyWrite, 2) |-> $stable(loop2IntMult_r))
    else $error("multiplier moved without apply");
  AST_APPLY_READS_ZERO: assert property (regRead && regAddr == 12'h192 |=> !regRdata_r[15])
    else $error("apply bit read back as one");
  // anything at 200h and above is unmapped and must read zero
  AST_UNMAPPED_READ: assert property (regRead && regAddr[11:9] != 3'h0 |=> regRdata_r == 16'h0000)
    else $error("unmapped read not zero");
  AST_DEN_FOLLOWS: assert property (regWrite && regAddr == 12'h194 |->
    ##2 loop2FracDen_r == $past(regWdata, 2)) else $error("denominator not applied");
  AST_RATIO_DECODE: assert property (regWrite && regAddr == 12'h195 |-> ##2
    loop2OscRatio_r == ($past(regWdata[10], 2) ? 5'h10 : 5'h01 << $past(regWdata[9:8], 2)))
    else $error("ratio decode wrong");
  // reserved divider codes fall back to two
  AST_OUTDIV_DECODE: assert property (regWrite && regAddr == 12'h195 |-> ##2
    loop2OutDivider_r == ($past(regWdata[3:2], 2) == 2'h0 ? 3'h2 : $past(regWdata[3:1], 2)))
    else $error("output divider wrong");
  AST_REFDIV_DECODE: assert property (regWrite && regAddr == 12'h196 |-> ##2
    loop2RefDivider_r == 4'h1 << $past(regWdata[7:6], 2)) else $error("ref divider wrong");
  AST_GAIN_DECODE: assert property (regWrite && regAddr == 12'h199 |-> ##2
    loop2LoopGain_r == ($past(regWdata[5], 2) ? 9'h100 : 9'h001 << $past(regWdata[4:2], 2)))
    else $error("gain decode wrong");

  // main scenarios reached
  COV_APPLY: cover property (regWrite && regAddr == 12'h192 && regWdata[15] && loop2Run_r);
  COV_GOOD: cover property ($rose(clockGood_r[1]));
  COV_LOCK: cover property ($rose(lockStat_r[1]));
endmodule

bind flc_loop_ctrl flc_loop_ctrl_checker u_chk (.*);

/* test/fll_config_spread_freerun_test.sv */
// self-checking bench for the two-loop control register block
`timescale 1ns/100ps
module fll_config_spread_freerun_test;
  // bench drives and counters
  logic        sys_clk;
  logic        reset_n  = 1'b0;
  logic [11:0] regAddr  = 12'h000;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic [15:0] regWdata = 16'h0000;
  logic [10:0] refPins  = 11'h000;
  logic [2:0]  refCnt   = 3'h0;
  int          miscompares = 0;
  int          checks = 0;
  int          i;
  // design outputs
  wire [15:0] regRdata_r, loop2FracNum_r, loop2FracDen_r;
  wire [9:0]  loop2IntMult_r;
  wire [8:0]  loop2LoopGain_r;
  wire [4:0]  loop2OscRatio_r;
  wire [3:0]  loop2RefDivider_r, statusEvent_r;
  wire [2:0]  loop2OutDivider_r;
  wire [1:0]  loop2SpreadType_r, loop2SpreadDepth_r, loop2SpreadRate_r, clockGood_r;
  wire [1:0]  loop1SpreadType_r, loop1SpreadDepth_r, loop1SpreadRate_r, lockStat_r;
  wire        loop2Run_r, loop2Hold_r, loop1Run_r, loop1Hold_r;
  wire        loop2SyncRun_r, loop2SyncBandwidth_r;

  // short start and lock counts keep the run brief
  flc_loop_ctrl #(.START_CYCLES(16'h0004), .LOCK_CYCLES(16'h0010)) u_dut (.*);

  // ----
  // clock and reference pins
  // ----
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // reference pins 0 to 8 toggle each 8 cycles so any valid pin source has edges
  always @(posedge sys_clk)
  begin
    refCnt <= refCnt + 3'h1;
    if (refCnt == 3'h7)
      refPins <= refPins ^ 11'h1ff;
  end

  // ----
  // access tasks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // write is taken at the edge after the strobe is raised
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
    #1 chk(regRdata_r, exp);
  endtask

  // decoded outputs land one edge after the write is taken
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // bounded wait on a status level; running out counts as a mismatch
  task automatic waitFor(input int sel, input logic want);
    int   n;
    logic v;
    for (n = 0; n < 5000; n++)
    begin
      @(posedge sys_clk);
      #1;
      v = sel == 0 ? clockGood_r[1] : sel == 1 ? lockStat_r[1] :
          sel == 2 ? clockGood_r[0] : loop2Hold_r;
      if (v === want)
        break;
    end
    chk({15'h0000, v}, {15'h0000, want});
    if (v !== want)
      tally_and_finish();
  endtask

  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(12'h171, 16'h0002);
    rd(12'h191, 16'h0000);
    rd(12'h192, 16'h0008);
    rd(12'h193, 16'h0018);
    rd(12'h194, 16'h007d);
    rd(12'h195, 16'h0004);
    rd(12'h1a2, 16'h0000);
    rd(12'h1a3, 16'h0000);
    rd(12'h1a4, 16'h0000);
    rd(12'h1a6, 16'h0000);
    rd(12'h1a7, 16'h0001);
    $display("reset values done");
    // every code of each decoded field, loop 2 spread differs from loop 1
    for (i = 0; i < 16; i++)
    begin
      wr(12'h195, {5'h00, i[2:0], 4'h0, i[2:0], 1'b0});
      wr(12'h196, {8'h00, i[1:0], 6'h00});
      wr(12'h199, {10'h000, i[3:0], 2'h0});
      wr(12'h189, {10'h000, i[1:0], i[1:0], i[1:0]});
      wr(12'h1a9, {10'h000, i[1:0], i[1:0], ~i[1:0]});
      wr(12'h1a5, {5'h00, i[2:0], 8'h00});
      settle();
      chk(16'(loop2OscRatio_r), i[2] ? 16'h0010 : 16'h0001 << i[1:0]);
      chk(16'(loop2OutDivider_r), i[2:1] == 2'h0 ? 16'h0002 : 16'(i[2:0]));
      chk(16'(loop2RefDivider_r), 16'h0001 << i[1:0]);
      chk(16'(loop2LoopGain_r), i[3] ? 16'h0100 : 16'h0001 << i[2:0]);
      chk(16'({loop1SpreadDepth_r, loop1SpreadRate_r, loop1SpreadType_r}),
          16'({i[1:0], i[1:0], i[1:0]}));
      chk(16'({loop2SpreadDepth_r, loop2SpreadRate_r, loop2SpreadType_r}),
          16'({i[1:0], i[1:0], ~i[1:0]}));
      rd(12'h1a5, {5'h00, i[2:0], 8'h00});
    end
    $display("decode tables done");
    wr(12'h196, 16'h0000);
    wr(12'h192, 16'h0010);
    settle();
    chk(16'(loop2IntMult_r), 16'h0010);
    wr(12'h1a7, 16'h0000);
    wr(12'h1a1, 16'h0001);
    wr(12'h191, 16'h0001);
    wr(12'h192, 16'h0033);
    wr(12'h193, 16'h1234);
    wr(12'h194, 16'h0055);
    settle();
    chk(16'(loop2IntMult_r), 16'h0010);
    chk(loop2FracNum_r, 16'h0018);
    chk(loop2FracDen_r, 16'h0055);
    chk(16'(loop2SyncBandwidth_r), 16'h0000);
    chk(16'(loop2SyncRun_r), 16'h0001);
    wr(12'h192, 16'h8033);
    settle();
    chk(16'(loop2IntMult_r), 16'h0033);
    chk(loop2FracNum_r, 16'h1234);
    rd(12'h192, 16'h0033);
    $display("apply strobe done");
    waitFor(0, 1'b1);
    waitFor(1, 1'b1);
    wr(12'h191, 16'h0003);
    settle();
    chk(16'(loop2Hold_r), 16'h0001);
    chk(16'(loop2IntMult_r), 16'h0033);
    wr(12'h191, 16'h0001);
    waitFor(3, 1'b0);
    // a reserved source carries no reference, so the loop must free-run
    wr(12'h196, 16'h0002);
    waitFor(3, 1'b1);
    wr(12'h196, 16'h0000);
    waitFor(3, 1'b0);
    waitFor(1, 1'b1);
    wr(12'h171, 16'h0003);
    waitFor(2, 1'b1);
    chk(16'(loop1Hold_r), 16'h0001);
    // loop 1 clock-good rose one edge ago, so its change event stands now
    @(posedge sys_clk);
    #1 chk(16'(statusEvent_r), 16'h0001);
    chk(16'({loop1Run_r, loop2Run_r}), 16'h0003);
    rd(12'h1af, 16'h002b);
    $display("status and free-run done");
    wr(12'h200, 16'hffff);
    rd(12'h200, 16'h0000);
    $display("unmapped access done");
    tally_and_finish();
  end
endmodule
